// file: hdl/pkfl_pkg.sv
// shared constants, register map and carrier types of the packet fifo level tracker
package pkfl_pkg;

  localparam int unsigned APB_AW = 8;
  localparam logic [APB_AW-1:0] OFF_SHORT_PACKET_DELAY = 8'h6c;
  localparam logic [APB_AW-1:0] OFF_RX_FIFO_LEVEL_DEBUG = 8'h70;
  localparam logic [APB_AW-1:0] OFF_RX_FIFO_POINTER_DEBUG = 8'h74;
  localparam logic [APB_AW-1:0] OFF_TX_FIFO_LEVEL_DEBUG = 8'h78;

  localparam int unsigned DELAY_W = 16;
  localparam int unsigned DELAY_LSB = 0;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 16'h0800;
  localparam int unsigned DELAY_UNIT_PS = 16667;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CLK_PERIOD_PS = CLK_PERIOD_NS * 1000;

  localparam int unsigned RX_LVL_W = 14;
  localparam int unsigned RX_PTR_W = 13;
  localparam int unsigned TX_LVL_W = 12;
  localparam int unsigned TX_PTR_W = 11;
  localparam int unsigned RX_RD_LVL_LSB = 16;
  localparam int unsigned RX_WR_LVL_LSB = 0;
  localparam int unsigned RX_RD_PTR_LSB = 16;
  localparam int unsigned RX_WR_PTR_LSB = 0;
  localparam int unsigned TX_RD_LVL_LSB = 16;
  localparam int unsigned TX_WR_LVL_LSB = 0;
  localparam logic [RX_LVL_W-1:0] RX_LVL_RESET = 14'h0000;
  localparam logic [RX_PTR_W-1:0] RX_PTR_RESET = 13'h0000;
  localparam logic [TX_LVL_W-1:0] TX_LVL_RESET = 12'h000;
  localparam logic [TX_PTR_W-1:0] TX_PTR_RESET = 11'h000;

  localparam int unsigned IN_FIFO_W = 2;
  localparam int unsigned IN_FIFO_DEPTH = 4;

  // one dword written into a packet fifo
  typedef struct packed {
    logic dword;
    logic last;
    logic err;
  } pkfl_wr_type;

  // one dword read out of a packet fifo, or a rewind of the packet in progress
  typedef struct packed {
    logic dword;
    logic last;
    logic rewind;
  } pkfl_rd_type;

  // entry of the mac-side input buffer: last dword of frame, frame failed its fcs
  typedef struct packed {
    logic last;
    logic err;
  } pkfl_mac_type;

  typedef enum logic [1:0] {
    DLY_IDLE = 2'b01,
    DLY_WAIT = 2'b10
  } pkfl_dly_state_type;

endpackage

// file: hdl/pkfl_top.sv
// packet fifo level tracking, mac input buffer and short packet delay with apb registers
//
// Behaviour
// - wait programmed delay before short bulk-in packet
// - delay counts 16.667 ns units, resets 800h
// - read level: whole packet added, minus per read
// - write level: plus per write, minus read packet
// - rx read rewind restores dwords read out
// - usb error rewinds rx read for retransmit
// - fcs error rewinds frame, restores write level
// - tx read side ignores rewinds
// - tx write side rewinds errored usb packet
// - rx levels at 29:16 and 13:0, read-only
// - tx levels at 27:16 and 11:0, read-only
// - rx pointers at 28:16 and 12:0, read-only
`timescale 1ns/1ns

module pkfl_fifo #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_r];

  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + (AW+1)'(1);
    end else if (pop && !push) begin
      count_nxt = count_r - (AW+1)'(1);
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST_C) ? '0 : wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST_C) ? '0 : rd_ptr_r + AW'(1);
      end
    end
  end

  // ready and valid come from flops so the source never sees a combinational path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      count_r <= count_nxt;
      in_ready <= (count_nxt != DEPTH_C);
      out_valid <= (count_nxt != '0);
    end
  end
endmodule

module pkfl_tracker #(
  parameter int unsigned LW = 14,
  parameter int unsigned PW = 13,
  parameter bit RD_REWIND = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pkfl_pkg::pkfl_wr_type wr,
  input wire pkfl_pkg::pkfl_rd_type rd,
  output logic [LW-1:0] rd_lvl_r,
  output logic [LW-1:0] wr_lvl_r,
  output logic [PW-1:0] rd_ptr_r,
  output logic [PW-1:0] wr_ptr_r
);
  import pkfl_pkg::*;

  logic [LW-1:0] wr_cnt_r;
  logic [LW-1:0] rd_cnt_r;
  logic [PW-1:0] wr_start_r;
  logic [PW-1:0] rd_start_r;
  logic [LW-1:0] rd_add;
  logic [LW-1:0] rd_sub;
  logic [LW-1:0] wr_add;
  logic [LW-1:0] wr_sub;
  logic wr_abort;
  logic wr_end;
  logic rd_rewind;
  logic rd_end;

  assign wr_abort = wr.dword && wr.last && wr.err;
  assign wr_end = wr.dword && wr.last && !wr.err;
  // a rewind outranks a read in the same cycle
  assign rd_rewind = RD_REWIND && rd.rewind;
  assign rd_end = rd.dword && rd.last && !rd_rewind;

  always_comb begin
    rd_add = '0;
    rd_sub = '0;
    wr_add = '0;
    wr_sub = '0;
    if (wr_end) begin
      rd_add = wr_cnt_r + LW'(1);
    end
    if (rd_rewind) begin
      rd_add = rd_add + rd_cnt_r;
    end else if (rd.dword) begin
      rd_sub = LW'(1);
    end
    if (wr_abort) begin
      wr_sub = wr_cnt_r;
    end else if (wr.dword) begin
      wr_add = LW'(1);
    end
    if (rd_end) begin
      wr_sub = wr_sub + rd_cnt_r + LW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_lvl_r <= '0;
      wr_lvl_r <= '0;
    end else begin
      rd_lvl_r <= rd_lvl_r + rd_add - rd_sub;
      wr_lvl_r <= wr_lvl_r + wr_add - wr_sub;
    end
  end

  // write side: a failed frame drops the pointer back to the frame start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      wr_start_r <= '0;
      wr_cnt_r <= '0;
    end else if (wr_abort) begin
      wr_ptr_r <= wr_start_r;
      wr_cnt_r <= '0;
    end else if (wr_end) begin
      wr_ptr_r <= wr_ptr_r + PW'(1);
      wr_start_r <= wr_ptr_r + PW'(1);
      wr_cnt_r <= '0;
    end else if (wr.dword) begin
      wr_ptr_r <= wr_ptr_r + PW'(1);
      wr_cnt_r <= wr_cnt_r + LW'(1);
    end
  end

  // read side: a rewind replays the packet from its first dword
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_r <= '0;
      rd_start_r <= '0;
      rd_cnt_r <= '0;
    end else if (rd_rewind) begin
      rd_ptr_r <= rd_start_r;
      rd_cnt_r <= '0;
    end else if (rd_end) begin
      rd_ptr_r <= rd_ptr_r + PW'(1);
      rd_start_r <= rd_ptr_r + PW'(1);
      rd_cnt_r <= '0;
    end else if (rd.dword) begin
      rd_ptr_r <= rd_ptr_r + PW'(1);
      rd_cnt_r <= rd_cnt_r + LW'(1);
    end
  end
endmodule

module pkfl_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pkfl_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mac_rx_valid,
  output logic mac_rx_ready,
  input wire pkfl_pkg::pkfl_mac_type mac_rx_data,
  input wire pkfl_pkg::pkfl_rd_type usb_rx_rd,
  input wire pkfl_pkg::pkfl_wr_type usb_tx_wr,
  input wire pkfl_pkg::pkfl_rd_type mac_tx_rd,
  input wire logic short_pkt_req,
  output logic short_pkt_go,
  output logic short_pkt_busy
);
  import pkfl_pkg::*;

  logic [DELAY_W-1:0] delay_r;
  logic [RX_LVL_W-1:0] rx_rd_lvl;
  logic [RX_LVL_W-1:0] rx_wr_lvl;
  logic [RX_PTR_W-1:0] rx_rd_ptr;
  logic [RX_PTR_W-1:0] rx_wr_ptr;
  logic [TX_LVL_W-1:0] tx_rd_lvl;
  logic [TX_LVL_W-1:0] tx_wr_lvl;
  logic buf_valid;
  logic buf_ready;
  pkfl_mac_type buf_data;
  pkfl_wr_type rx_wr;
  logic [31:0] rdata;
  logic mapped;
  logic setup;
  logic wr_access;
  pkfl_dly_state_type dly_state_r;
  logic [31:0] dly_target_r;
  logic [31:0] dly_elapsed_r;
  logic [31:0] dly_elapsed_nxt;

  // the mac side is buffered; draining stops when the rx fifo holds its full span
  pkfl_fifo #(
    .WIDTH(IN_FIFO_W),
    .DEPTH(IN_FIFO_DEPTH)
  ) u_in_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(mac_rx_valid),
    .in_ready(mac_rx_ready),
    .in_data(mac_rx_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );
  assign buf_ready = (rx_wr_lvl < RX_LVL_W'(1 << RX_PTR_W));
  assign rx_wr = '{dword: buf_valid && buf_ready, last: buf_data.last, err: buf_data.err};
  pkfl_tracker #(
    .LW(RX_LVL_W),
    .PW(RX_PTR_W),
    .RD_REWIND(1'b1)
  ) u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .wr(rx_wr),
    .rd(usb_rx_rd),
    .rd_lvl_r(rx_rd_lvl),
    .wr_lvl_r(rx_wr_lvl),
    .rd_ptr_r(rx_rd_ptr),
    .wr_ptr_r(rx_wr_ptr)
  );
  pkfl_tracker #(
    .LW(TX_LVL_W),
    .PW(TX_PTR_W),
    .RD_REWIND(1'b0)
  ) u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .wr(usb_tx_wr),
    .rd(mac_tx_rd),
    .rd_lvl_r(tx_rd_lvl),
    .wr_lvl_r(tx_wr_lvl),
    .rd_ptr_r(),
    .wr_ptr_r()
  );
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pready && pwrite;
  always_comb begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      OFF_SHORT_PACKET_DELAY: begin
        rdata[DELAY_LSB +: DELAY_W] = delay_r;
      end
      OFF_RX_FIFO_LEVEL_DEBUG: begin
        rdata[RX_RD_LVL_LSB +: RX_LVL_W] = rx_rd_lvl;
        rdata[RX_WR_LVL_LSB +: RX_LVL_W] = rx_wr_lvl;
      end
      OFF_RX_FIFO_POINTER_DEBUG: begin
        rdata[RX_RD_PTR_LSB +: RX_PTR_W] = rx_rd_ptr;
        rdata[RX_WR_PTR_LSB +: RX_PTR_W] = rx_wr_ptr;
      end
      OFF_TX_FIFO_LEVEL_DEBUG: begin
        rdata[TX_RD_LVL_LSB +: TX_LVL_W] = tx_rd_lvl;
        rdata[TX_WR_LVL_LSB +: TX_LVL_W] = tx_wr_lvl;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end
  // answer is prepared during setup, so every access completes with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? rdata : 32'h0000_0000;
    end
  end

  // only the delay field is writable; writes to the debug words change nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_r <= DELAY_RESET;
    end else if (wr_access && paddr == OFF_SHORT_PACKET_DELAY) begin
      delay_r <= pwdata[DELAY_LSB +: DELAY_W];
    end
  end

  // time is kept in picoseconds so the 16.667 ns step needs no divider; least time rounds up
  assign dly_elapsed_nxt = dly_elapsed_r + CLK_PERIOD_PS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_state_r <= DLY_IDLE;
      dly_target_r <= 32'h0000_0000;
      dly_elapsed_r <= 32'h0000_0000;
      short_pkt_go <= 1'b0;
      short_pkt_busy <= 1'b0;
    end else begin
      short_pkt_go <= 1'b0;
      case (dly_state_r)
        DLY_IDLE: begin
          if (short_pkt_req) begin
            dly_target_r <= 32'(delay_r) * 32'(DELAY_UNIT_PS);
            dly_elapsed_r <= 32'h0000_0000;
            dly_state_r <= DLY_WAIT;
            short_pkt_busy <= 1'b1;
          end
        end
        DLY_WAIT: begin
          dly_elapsed_r <= dly_elapsed_nxt;
          if (dly_elapsed_nxt >= dly_target_r) begin
            short_pkt_go <= 1'b1;
            short_pkt_busy <= 1'b0;
            dly_state_r <= DLY_IDLE;
          end
        end
        default: begin
          dly_state_r <= DLY_IDLE;
          short_pkt_busy <= 1'b0;
        end
      endcase
    end
  end
endmodule

// file: bench/pkfl_monitor.sv
// port checker for the packet fifo level tracker
`timescale 1ns/1ns
module pkfl_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pkfl_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic short_pkt_req,
  input wire logic short_pkt_go,
  input wire logic short_pkt_busy
);
  import pkfl_pkg::*;
  logic rd_acc;
  assign rd_acc = pready && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg_answer_a: assert property (psel && !penable |=> pready)
    else $error("apb access not answered");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  idle_quiet_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read bus not quiet");
  addr_decode_a: assert property (pready |-> pslverr == !(paddr inside {8'h6c, 8'h70, 8'h74, 8'h78}))
    else $error("pslverr wrong for address");
  dly_rsvd_a: assert property (rd_acc && paddr == 8'h6c |-> prdata[31:16] == 16'h0)
    else $error("delay upper bits set");
  rx_lvl_rsvd_a: assert property (rd_acc && paddr == 8'h70 |-> !prdata[31:30] && !prdata[15:14])
    else $error("rx level reserved bits set");
  rx_ptr_rsvd_a: assert property (rd_acc && paddr == 8'h74 |-> !prdata[31:29] && !prdata[15:13])
    else $error("rx pointer reserved bits set");
  tx_lvl_rsvd_a: assert property (rd_acc && paddr == 8'h78 |-> !prdata[31:28] && !prdata[15:12])
    else $error("tx level reserved bits set");
  dly_start_a: assert property (short_pkt_req && !short_pkt_busy |=> short_pkt_busy)
    else $error("delay did not start");
  go_pulse_a: assert property (short_pkt_go |-> $past(short_pkt_busy) && !short_pkt_busy ##1 !short_pkt_go)
    else $error("send pulse malformed");
  busy_end_a: assert property ($fell(short_pkt_busy) |-> short_pkt_go)
    else $error("delay ended without send");
  cover property (short_pkt_go);
  cover property (pready && pslverr);
  cover property (pready && pwrite && paddr == 8'h6c);
endmodule

// file: bench/pkfl_mac_model.sv
// behavioural ethernet mac offering received frame dwords
`timescale 1ns/1ns
module pkfl_mac_model (
  input wire logic pclk,
  output logic mac_rx_valid,
  input wire logic mac_rx_ready,
  output pkfl_pkg::pkfl_mac_type mac_rx_data
);
  initial begin
    mac_rx_valid = 1'h0;
    mac_rx_data = '0;
  end
  // offer is held until ready is seen at an edge
  task send(input int n, input bit e);
    @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      mac_rx_valid <= 1'h1;
      mac_rx_data <= {i == n - 1, e && i == n - 1};
      do @(posedge pclk); while (mac_rx_ready !== 1'h1);
    end
    mac_rx_valid <= 1'h0;
    // idle data flips so a stale value cannot pass for a frame
    mac_rx_data <= ~mac_rx_data;
  endtask
endmodule

// file: bench/pkfl_top_tb.sv
// testbench for the packet fifo level tracker
`timescale 1ns/1ns
module pkfl_top_tb;
  import pkfl_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic err;} pkfl_row_type;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, short_pkt_req = 1'h0, pready, pslverr, e;
  logic mac_rx_valid, mac_rx_ready, short_pkt_go, short_pkt_busy;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  pkfl_mac_type mac_rx_data;
  pkfl_rd_type usb_rx_rd = '0, mac_tx_rd = '0;
  pkfl_wr_type usb_tx_wr = '0;
  int num_errors = 0, n_checks = 0, cyc = 0;
  pkfl_row_type rows[6] = '{'{8'h6c, 32'h800, 1'h0}, '{8'h70, 32'h0, 1'h0},
    '{8'h74, 32'h0, 1'h0}, '{8'h78, 32'h0, 1'h0}, '{8'h7c, 32'h0, 1'h1},
    '{8'h00, 32'h0, 1'h1}};
  always #50 pclk = ~pclk;
  pkfl_top i_dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mac_rx_valid, .mac_rx_ready, .mac_rx_data, .usb_rx_rd,
    .usb_tx_wr, .mac_tx_rd, .short_pkt_req, .short_pkt_go, .short_pkt_busy);
  pkfl_mac_model i_mac(.pclk, .mac_rx_valid, .mac_rx_ready, .mac_rx_data);
  task summarize;
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      summarize();
    end
  end
  task chk(input string s, input logic [31:0] x, input logic [31:0] y);
    n_checks++;
    if (y !== x) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", s, x, y);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk("prdata", x, q);
  endtask
  // w: 0 usb rx read, 1 usb tx write, 2 mac tx read
  task pulse(input int w, input logic [2:0] v);
    @(posedge pclk);
    case (w)
      0: usb_rx_rd <= v;
      1: usb_tx_wr <= v;
      default: mac_tx_rd <= v;
    endcase
    @(posedge pclk);
    usb_rx_rd <= '0;
    usb_tx_wr <= '0;
    mac_tx_rd <= '0;
  endtask
  task dly(input int d);
    int n, c;
    n = (d * DELAY_UNIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (n < 1) n = 1;
    @(posedge pclk);
    short_pkt_req <= 1'h1;
    c = -1;
    // go is seen one edge after it rises, hence n + 1
    do begin
      @(posedge pclk);
      short_pkt_req <= 1'h0;
      c++;
    end while (short_pkt_go !== 1'h1 && c < 500);
    chk("go_delay", n + 1, c);
  endtask
  task run_rows;
    foreach (rows[i]) begin
      apb(1'h0, rows[i].a, 32'h0);
      chk("prdata", rows[i].d, q);
      chk("pslverr", rows[i].err, e);
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    run_rows();
    dly(32'h800);
    apb(1'h1, 8'h6c, 32'hffff_0006);
    rd(8'h6c, 32'h6);
    dly(6);
    apb(1'h1, 8'h6c, 32'h0);
    dly(0);
    apb(1'h1, 8'h70, 32'hffff_ffff);
    rd(8'h70, 32'h0);
    i_mac.send(3, 1'h0);
    repeat (3) @(posedge pclk);
    rd(8'h70, 32'h0003_0003);
    rd(8'h74, 32'h3);
    i_mac.send(2, 1'h1);
    repeat (3) @(posedge pclk);
    rd(8'h70, 32'h0003_0003);
    rd(8'h74, 32'h3);
    repeat (2) pulse(0, 3'h4);
    rd(8'h70, 32'h0001_0003);
    rd(8'h74, 32'h0002_0003);
    pulse(0, 3'h1);
    rd(8'h70, 32'h0003_0003);
    rd(8'h74, 32'h3);
    repeat (2) pulse(0, 3'h4);
    pulse(0, 3'h6);
    rd(8'h70, 32'h0);
    pulse(1, 3'h4);
    pulse(1, 3'h6);
    rd(8'h78, 32'h0002_0002);
    pulse(1, 3'h4);
    pulse(1, 3'h7);
    rd(8'h78, 32'h0002_0002);
    pulse(1, 3'h6);
    pulse(2, 3'h4);
    pulse(2, 3'h1);
    rd(8'h78, 32'h0002_0003);
    pulse(2, 3'h6);
    rd(8'h78, 32'h0001_0001);
    // fill rx to its stall level, then the buffer until it refuses
    i_mac.send(8192, 1'h0);
    repeat (3) @(posedge pclk);
    rd(8'h70, 32'h2000_2000);
    i_mac.send(4, 1'h0);
    repeat (2) @(posedge pclk);
    chk("mac_rx_ready", 1'h0, mac_rx_ready);
    repeat (8191) pulse(0, 3'h4);
    pulse(0, 3'h6);
    repeat (8) @(posedge pclk);
    chk("mac_rx_ready", 1'h1, mac_rx_ready);
    rd(8'h70, 32'h0004_0004);
    // a reset in mid-run must restore every field, with all of them away from reset values
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (16) @(posedge pclk);
    chk("mac_rx_ready", 1'h0, mac_rx_ready);
    presetn <= 1'h1;
    run_rows();
    summarize();
  end
endmodule
bind pkfl_top pkfl_monitor i_mon(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .short_pkt_req, .short_pkt_go, .short_pkt_busy);
